// *** rtl/qwsc_device.sv ***
/*
 * Wiper device end: frame receiver and readback shifter on the link
 * clock; stored settings, wiper outputs and store timer on clk_sys.
 * Assumes the host keeps the link clock running while selected or busy.
 */
`timescale 1ns/1ps
module qwsc_device #(
	parameter int unsigned BUSY_CYCLES = qwsc_pkg::BUSY_CYCLES_DEF
) (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// link pins
	qwsc_link_if.dev link,
	// supply detector, asynchronous
	input wire logic supply_ok,
	// wiper settings
	output qwsc_pkg::qwsc_bank_t wiper_level
);
	localparam int TMR_W = $clog2(BUSY_CYCLES + 1);

	// link domain
	logic lrst_a;
	logic lrst;
	logic sup_a;
	logic sup_s;
	qwsc_pkg::qwsc_dev_state_e st;
	logic [3:0] bit_cnt;
	qwsc_pkg::qwsc_ch_t ch;
	qwsc_pkg::qwsc_byte_t data_sh;
	qwsc_pkg::qwsc_byte_t next_data;
	qwsc_pkg::qwsc_ch_t addr_now;
	qwsc_pkg::qwsc_byte_t out_sh;
	qwsc_pkg::qwsc_bank_t held;
	qwsc_pkg::qwsc_bank_t nv_copy;
	qwsc_pkg::qwsc_ch_t xfer_ch;
	qwsc_pkg::qwsc_byte_t xfer_val;
	logic commit_request_valid;
	logic load_tgl;
	logic commit_tgl;
	logic dn_a;
	logic dn_b;
	logic dn_c;
	logic done_ev;
	logic start_store;
	logic last_data;
	logic so;
	logic so_oe;
	logic flag;

	// system domain
	logic cs_a;
	logic cs_s;
	logic ld_a;
	logic ld_b;
	logic ld_c;
	logic cm_a;
	logic cm_b;
	logic cm_c;
	logic ld_ev;
	logic cm_ev;
	qwsc_pkg::qwsc_bank_t nv;
	logic [TMR_W-1:0] tmr;
	logic running;
	logic done_tgl;
	logic [5:0] lrst_cnt;

	// reset and level crossings into the link domain
	always_ff @(posedge link.link_clk) begin
		// stretched: the host holds the link clock still during srst
		lrst_a <= !lrst_cnt[$high(lrst_cnt)];
		lrst <= lrst_a;
		sup_a <= supply_ok;
		sup_s <= sup_a;
	end

	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			dn_a <= 1'b0;
			dn_b <= 1'b0;
			dn_c <= 1'b0;
		end else begin
			dn_a <= done_tgl;
			dn_b <= dn_a;
			dn_c <= dn_b;
		end
	end

	assign done_ev = dn_b ^ dn_c;
	assign next_data = {link.serial_in, data_sh[qwsc_pkg::DATA_W-1:1]};
	assign addr_now = {link.serial_in, ch[1]};
	assign last_data = (st == qwsc_pkg::D_DATA) && (bit_cnt == qwsc_pkg::DATA_LAST);
	// commit seen on the first gap edge, only with a good supply
	assign start_store = (st == qwsc_pkg::D_GAP) && (bit_cnt == 4'h0) && commit_request_valid &&
		link.chip_sel && link.commit_request && sup_s;

	// frame sequencer
	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			st <= qwsc_pkg::D_IDLE;
			bit_cnt <= 4'h0;
		end else if (!link.chip_sel && st != qwsc_pkg::D_BUSY) begin
			// deselect abandons any partial frame
			st <= qwsc_pkg::D_IDLE;
			bit_cnt <= 4'h0;
		end else begin
			unique case (st)
				qwsc_pkg::D_IDLE: begin
					if (link.serial_in) begin
						st <= qwsc_pkg::D_ADDR;
						bit_cnt <= 4'h0;
					end
				end
				qwsc_pkg::D_ADDR: begin
					bit_cnt <= bit_cnt + 4'h1;
					if (bit_cnt == qwsc_pkg::ADDR_LAST) begin
						st <= qwsc_pkg::D_DATA;
						bit_cnt <= 4'h0;
					end
				end
				qwsc_pkg::D_DATA: begin
					bit_cnt <= bit_cnt + 4'h1;
					if (last_data) begin
						st <= qwsc_pkg::D_GAP;
						bit_cnt <= 4'h0;
					end
				end
				qwsc_pkg::D_GAP: begin
					bit_cnt <= bit_cnt + 4'h1;
					if (start_store) begin
						st <= qwsc_pkg::D_BUSY;
					end else if (bit_cnt == qwsc_pkg::GAP_LAST) begin
						st <= qwsc_pkg::D_IDLE;
					end
				end
				qwsc_pkg::D_BUSY: begin
					// serial input is not looked at here
					if (done_ev) begin
						st <= qwsc_pkg::D_IDLE;
					end
				end
				default: begin
					st <= qwsc_pkg::D_IDLE;
				end
			endcase
		end
	end

	// address and data shift, LSB first
	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			ch <= '0;
			data_sh <= '0;
		end else if (st == qwsc_pkg::D_ADDR) begin
			ch <= addr_now;
		end else if (st == qwsc_pkg::D_DATA) begin
			data_sh <= next_data;
		end
	end

	// programming register, handed to clk_sys by toggles
	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			xfer_ch <= '0;
			xfer_val <= '0;
			commit_request_valid <= 1'b0;
			load_tgl <= 1'b0;
			commit_tgl <= 1'b0;
		end else begin
			if (last_data && link.chip_sel) begin
				xfer_ch <= ch;
				xfer_val <= next_data;
				commit_request_valid <= 1'b1;
				load_tgl <= ~load_tgl;
			end else if (st == qwsc_pkg::D_GAP && bit_cnt == qwsc_pkg::GAP_LAST) begin
				commit_request_valid <= 1'b0;
			end else if (start_store) begin
				commit_request_valid <= 1'b0;
			end
			if (start_store) begin
				commit_tgl <= ~commit_tgl;
			end
		end
	end

	// link-side copies of working and stored values
	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			held <= qwsc_pkg::NV_INIT;
			nv_copy <= qwsc_pkg::NV_INIT;
		end else begin
			if (last_data && link.chip_sel) begin
				held[ch] <= next_data;
			end else if (!link.chip_sel) begin
				held <= nv_copy;
			end
			if (start_store) begin
				nv_copy[xfer_ch] <= xfer_val;
			end
		end
	end

	// readback shifter and pin drivers
	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			so <= 1'b0;
			out_sh <= '0;
		end else if (st == qwsc_pkg::D_ADDR && bit_cnt == qwsc_pkg::ADDR_LAST) begin
			so <= held[addr_now][0];
			out_sh <= held[addr_now] >> 1;
		end else if (st == qwsc_pkg::D_DATA && bit_cnt != qwsc_pkg::DATA_LAST) begin
			so <= out_sh[0];
			out_sh <= out_sh >> 1;
		end
	end

	always_ff @(posedge link.link_clk) begin
		if (lrst) begin
			so_oe <= 1'b0;
			flag <= 1'b1;
		end else begin
			so_oe <= link.chip_sel && !start_store &&
				(st != qwsc_pkg::D_BUSY || done_ev);
			flag <= !(start_store || (st == qwsc_pkg::D_BUSY && !done_ev));
		end
	end

	assign link.serial_out = so;
	assign link.serial_out_oe = so_oe;
	assign link.store_done_flag = flag;

	// crossings into clk_sys; xfer words stay still for two link cycles
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			lrst_cnt <= '0;
			cs_a <= 1'b0;
			cs_s <= 1'b0;
			ld_a <= 1'b0;
			ld_b <= 1'b0;
			ld_c <= 1'b0;
			cm_a <= 1'b0;
			cm_b <= 1'b0;
			cm_c <= 1'b0;
		end else begin
			if (!lrst_cnt[$high(lrst_cnt)]) begin
				lrst_cnt <= lrst_cnt + 6'h01;
			end
			cs_a <= link.chip_sel;
			cs_s <= cs_a;
			ld_a <= load_tgl;
			ld_b <= ld_a;
			ld_c <= ld_b;
			cm_a <= commit_tgl;
			cm_b <= cm_a;
			cm_c <= cm_b;
		end
	end

	assign ld_ev = ld_b ^ ld_c;
	assign cm_ev = cm_b ^ cm_c;

	// stored values and wiper outputs, no link edge needed at power-up
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			nv <= qwsc_pkg::NV_INIT;
			wiper_level <= qwsc_pkg::NV_INIT;
		end else begin
			if (cm_ev) begin
				nv[xfer_ch] <= xfer_val;
			end
			if (ld_ev) begin
				wiper_level[xfer_ch] <= xfer_val;
			end else if (!cs_s) begin
				wiper_level <= nv;
			end
		end
	end

	// erase/write timer; counted on clk_sys, not the link clock
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tmr <= '0;
			running <= 1'b0;
			done_tgl <= 1'b0;
		end else if (cm_ev) begin
			tmr <= TMR_W'(BUSY_CYCLES - 1);
			running <= 1'b1;
		end else if (running) begin
			if (tmr == '0) begin
				running <= 1'b0;
				done_tgl <= ~done_tgl;
			end else begin
				tmr <= tmr - 1'b1;
			end
		end
	end
endmodule : qwsc_device

// *** rtl/qwsc_host.sv ***
/*
 * Host end: takes one command, makes the link clock by division, sends
 * a frame, reads the old value back, optionally commits and deselects.
 * Assumes a device on the other side of qwsc_link_if.
 */
`timescale 1ns/1ps
module qwsc_host (
	// system clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// link pins
	qwsc_link_if.host link,
	// command
	input wire logic cmd_valid,
	input wire qwsc_pkg::qwsc_ch_t cmd_ch,
	input wire qwsc_pkg::qwsc_byte_t cmd_val,
	input wire logic cmd_store,
	input wire logic cmd_release,
	output logic cmd_ready,
	// response
	output logic rsp_valid,
	output qwsc_pkg::qwsc_byte_t rsp_val,
	output logic rsp_stored,
	output logic rsp_failed
);
	logic [3:0] div_cnt;
	logic lclk;
	logic fall;
	logic rise;
	qwsc_pkg::qwsc_host_state_e hst;
	logic [3:0] step;
	logic [3:0] rcnt;
	qwsc_pkg::qwsc_frame_t fr;
	qwsc_pkg::qwsc_byte_t rd;
	logic cs;
	logic si;
	logic cm;
	logic store_r;
	logic rel_r;
	logic saw_low;
	logic so_a;
	logic so_s;
	logic fl_a;
	logic fl_s;

	// free-running divider: stops only during srst, so stores always finish
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			div_cnt <= 4'h0;
			lclk <= 1'b0;
		end else begin
			div_cnt <= (div_cnt == qwsc_pkg::LINK_DIV_M1) ? 4'h0 : div_cnt + 4'h1;
			if (div_cnt == qwsc_pkg::LINK_HALF_M1) begin
				lclk <= 1'b1;
			end else if (div_cnt == qwsc_pkg::LINK_DIV_M1) begin
				lclk <= 1'b0;
			end
		end
	end

	assign fall = (div_cnt == qwsc_pkg::LINK_DIV_M1);
	assign rise = (div_cnt == qwsc_pkg::LINK_HALF_M1);

	always_ff @(posedge clk_sys) begin
		so_a <= link.serial_out_line;
		so_s <= so_a;
		fl_a <= link.store_done_flag;
		fl_s <= fl_a;
	end

	// read data just before the rising edges counted RD_FIRST to RD_LAST
	always_ff @(posedge clk_sys) begin
		if (srst || hst != qwsc_pkg::H_FRAME) begin
			rcnt <= 4'h0;
		end else if (rise && step != 4'h0) begin
			// a rise before the first falling tick belongs to no frame
			rcnt <= rcnt + 4'h1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd <= '0;
		end else if (hst == qwsc_pkg::H_FRAME && rise &&
				rcnt >= qwsc_pkg::RD_FIRST && rcnt <= qwsc_pkg::RD_LAST) begin
			rd <= {so_s, rd[qwsc_pkg::DATA_W-1:1]};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hst <= qwsc_pkg::H_IDLE;
			cmd_ready <= 1'b0;
			step <= 4'h0;
			fr <= '0;
			cs <= 1'b0;
			si <= 1'b0;
			cm <= 1'b0;
			store_r <= 1'b0;
			rel_r <= 1'b0;
			saw_low <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_val <= '0;
			rsp_stored <= 1'b0;
			rsp_failed <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (hst)
				qwsc_pkg::H_IDLE: begin
					cmd_ready <= 1'b1;
					if (cmd_valid && cmd_ready) begin
						fr <= {cmd_val, cmd_ch, 1'b1};
						store_r <= cmd_store;
						rel_r <= cmd_release;
						cmd_ready <= 1'b0;
						step <= 4'h0;
						hst <= qwsc_pkg::H_FRAME;
					end
				end
				qwsc_pkg::H_FRAME: begin
					if (fall) begin
						// change data on the falling edge, device samples on rising
						step <= step + 4'h1;
						cs <= 1'b1;
						si <= fr[0];
						fr <= fr >> 1;
						if (step == qwsc_pkg::HS_COMMIT_ON) begin
							cm <= store_r;
						end else if (step == qwsc_pkg::HS_COMMIT_OFF) begin
							cm <= 1'b0;
						end
						if (step == qwsc_pkg::HS_END) begin
							saw_low <= 1'b0;
							hst <= qwsc_pkg::H_WAIT;
						end
					end
				end
				qwsc_pkg::H_WAIT: begin
					if (store_r && !fl_s) begin
						saw_low <= 1'b1;
					end else begin
						rsp_valid <= 1'b1;
						rsp_val <= rd;
						rsp_stored <= store_r && saw_low;
						rsp_failed <= store_r && !saw_low;
						step <= 4'h0;
						if (rel_r) begin
							cs <= 1'b0;
							hst <= qwsc_pkg::H_DESEL;
						end else begin
							hst <= qwsc_pkg::H_IDLE;
						end
					end
				end
				qwsc_pkg::H_DESEL: begin
					if (fall) begin
						step <= step + 4'h1;
						if (step == 4'(qwsc_pkg::CS_LOW_TICKS - 1)) begin
							hst <= qwsc_pkg::H_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign link.link_clk = lclk;
	assign link.chip_sel = cs;
	assign link.serial_in = si;
	assign link.commit_request = cm;
endmodule : qwsc_host

// *** rtl/qwsc_link_if.sv ***
/*
 * Link between host and wiper device: clock, select, data in, commit,
 * tri-state data out and busy flag.
 * Assumes the host makes the link clock; the serial output wire is
 * resolved here from its enable and reads high when released.
 */
`timescale 1ns/1ps
interface qwsc_link_if;
	logic link_clk;
	logic chip_sel;
	logic serial_in;
	logic commit_request;
	logic serial_out;
	logic serial_out_oe;
	logic store_done_flag;
	wire serial_out_line;
	// released line modelled as pulled high
	assign serial_out_line = serial_out_oe ? serial_out : 1'b1;
	modport dev (
		input link_clk,
		input chip_sel,
		input serial_in,
		input commit_request,
		output serial_out,
		output serial_out_oe,
		output store_done_flag
	);
	modport host (
		output link_clk,
		output chip_sel,
		output serial_in,
		output commit_request,
		input serial_out_line,
		input store_done_flag
	);
endinterface : qwsc_link_if

// *** rtl/qwsc_pkg.sv ***
/*
 * Shared constants and types for the quad wiper serial control link:
 * frame layout, timing counts, reset contents and state enumerations.
 * Assumes a 10 MHz system clock at both ends.
 */
// Summary of operation
// - data sampled and output on link rising edge
// - host keeps link clock running during store
// - wipers load stored values at power-up, clocklessly
// - store command drives busy flag low
// - busy ignores serial input, output undriven
// - low supply keeps flag high, no store
// - readback starts after start and address, LSB first
// - output driver enabled only while selected
// - host sends start, address, eight data bits
// - wiper takes new value after last data bit
// - host raises commit early, before post-frame edge
// - next frame accepted two cycles after last bit
// - each load shifts old value out, destructive
// - deselect ends read, reloads stored value
// - temporary loads anywhere, revert on deselect
// - uncommitted frame discarded two cycles later
// - host sends start bit one, LSB first
// - host leaves at least three cycles between frames
package qwsc_pkg;
	localparam int unsigned NUM_CH = 4;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 2;
	localparam int unsigned FRAME_BITS = 1 + ADDR_W + DATA_W;
	typedef logic [DATA_W-1:0] qwsc_byte_t;
	typedef logic [ADDR_W-1:0] qwsc_ch_t;
	typedef logic [NUM_CH-1:0][DATA_W-1:0] qwsc_bank_t;
	typedef logic [FRAME_BITS-1:0] qwsc_frame_t;
	// bit counters inside a frame
	localparam logic [3:0] ADDR_LAST = 4'h1;
	localparam logic [3:0] DATA_LAST = 4'h7;
	localparam logic [3:0] GAP_LAST = 4'h1;
	// host step counts, one per falling link edge; RD_FIRST and RD_LAST count rising edges
	localparam logic [3:0] HS_COMMIT_ON = 4'h1;
	localparam logic [3:0] HS_COMMIT_OFF = 4'hC;
	localparam logic [3:0] HS_END = 4'hD;
	localparam logic [3:0] RD_FIRST = 4'h3;
	localparam logic [3:0] RD_LAST = 4'hA;
	// timing
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned T_BUSY_MS = 5;
	localparam int unsigned BUSY_CYCLES_DEF = T_BUSY_MS * (CLK_HZ / 1000);
	localparam logic [3:0] LINK_DIV_M1 = 4'h9;
	localparam logic [3:0] LINK_HALF_M1 = 4'h4;
	localparam int unsigned LINK_PERIOD_NS = 10 * CLK_PERIOD_NS;
	localparam int unsigned T_CS_LOW_NS = 150;
	// one extra tick so the device sees a deselected edge
	localparam int unsigned CS_LOW_TICKS =
		(T_CS_LOW_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS + 1;
	// stored contents at power-up; arbitrary pattern
	localparam qwsc_bank_t NV_INIT = 32'h8040_2010;
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_DATA, D_GAP, D_BUSY} qwsc_dev_state_e;
	typedef enum logic [1:0] {H_IDLE, H_FRAME, H_WAIT, H_DESEL} qwsc_host_state_e;
endpackage : qwsc_pkg

// *** verif/quad_wiper_serial_control_tb.sv ***
/*
 * Self-checking bench: host and device joined by the link interface.
 * Assumes the package constants and a short store timer.
 */
`timescale 1ns/1ps
module quad_wiper_serial_control_tb;
	typedef struct packed {
		qwsc_pkg::qwsc_byte_t val;
		logic stored;
		logic failed;
		qwsc_pkg::qwsc_bank_t bank;
	} qwsc_note_s;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic supply_ok = 1'b1;
	logic cmd_valid = 1'b0;
	qwsc_pkg::qwsc_ch_t cmd_ch = 2'h0;
	qwsc_pkg::qwsc_byte_t cmd_val = 8'h00;
	logic cmd_store = 1'b0;
	logic cmd_release = 1'b0;
	logic cmd_ready;
	logic rsp_valid;
	qwsc_pkg::qwsc_byte_t rsp_val;
	logic rsp_stored;
	logic rsp_failed;
	qwsc_pkg::qwsc_bank_t wiper_level;
	qwsc_pkg::qwsc_bank_t stored_bank;
	qwsc_pkg::qwsc_bank_t work_bank;
	qwsc_note_s notes[$];
	qwsc_note_s note;
	int error_cnt = 0;
	int checks = 0;
	qwsc_link_if link ();
	qwsc_host qwsc_host_i (.clk_sys(clk_sys), .srst(srst), .link(link.host),
		.cmd_valid(cmd_valid), .cmd_ch(cmd_ch), .cmd_val(cmd_val), .cmd_store(cmd_store),
		.cmd_release(cmd_release), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_val(rsp_val), .rsp_stored(rsp_stored), .rsp_failed(rsp_failed));
	// short store timer keeps the run brief
	qwsc_device #(.BUSY_CYCLES(20)) qwsc_device_i (.clk_sys(clk_sys), .srst(srst),
		.link(link.dev), .supply_ok(supply_ok), .wiper_level(wiper_level));
	qwsc_props qwsc_props_i (.clk_sys(clk_sys), .srst(srst), .link_clk(link.link_clk),
		.chip_sel(link.chip_sel), .serial_in(link.serial_in),
		.commit_request(link.commit_request), .serial_out(link.serial_out),
		.serial_out_oe(link.serial_out_oe), .store_done_flag(link.store_done_flag));
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic mismatch(input string msg);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask : mismatch
	task automatic check_bank(input qwsc_pkg::qwsc_bank_t exp);
		checks++;
		if (wiper_level !== exp) mismatch("wiper levels differ");
	endtask : check_bank
	task automatic check_rsp(input qwsc_note_s exp);
		checks++;
		if (rsp_val !== exp.val || rsp_stored !== exp.stored || rsp_failed !== exp.failed)
			mismatch("response differs");
	endtask : check_rsp
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : print_verdict
	// one command; the note holds what the response must show
	task automatic send(input qwsc_pkg::qwsc_ch_t ch, input logic st, input logic rel,
		input logic sup);
		qwsc_note_s n;
		int i;
		qwsc_pkg::qwsc_byte_t v;
		v = qwsc_pkg::qwsc_byte_t'($urandom);
		i = 0;
		@(negedge clk_sys);
		supply_ok = sup;
		cmd_ch = ch;
		cmd_val = v;
		cmd_store = st;
		cmd_release = rel;
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1 && i < 500) begin
			@(negedge clk_sys);
			i++;
		end
		n.val = work_bank[ch];
		n.stored = st & sup;
		n.failed = st & ~sup;
		work_bank[ch] = v;
		if (st && sup) stored_bank[ch] = v;
		n.bank = work_bank;
		notes.push_back(n);
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 2000) begin
			@(negedge clk_sys);
			i++;
		end
		if (i >= 2000) mismatch("command never finished");
		if (rel) begin
			work_bank = stored_bank;
			repeat (5) @(negedge clk_sys);
			check_bank(stored_bank);
		end
	endtask : send
	always @(posedge clk_sys) begin
		if (rsp_valid === 1'b1) begin
			if (notes.size() == 0) begin
				mismatch("response without command");
			end else begin
				note = notes.pop_front();
				check_rsp(note);
				check_bank(note.bank);
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		mismatch("watchdog expired");
		print_verdict();
	end
	initial begin
		void'($urandom(32'hfbcb_548a));
		stored_bank = qwsc_pkg::NV_INIT;
		work_bank = qwsc_pkg::NV_INIT;
		// the device stretches its link-side reset past srst
		repeat (20) @(negedge clk_sys);
		check_bank(qwsc_pkg::NV_INIT);
		srst = 1'b0;
		repeat (50) @(negedge clk_sys);
		for (int k = 0; k < 8; k++) send(qwsc_pkg::qwsc_ch_t'(k), 1'b0, 1'b0, 1'b1);
		$display("test temporary loads done");
		send(2'h1, 1'b0, 1'b1, 1'b1);
		$display("test read and release done");
		send(2'h2, 1'b1, 1'b1, 1'b1);
		send(2'h3, 1'b1, 1'b1, 1'b0);
		$display("test store done");
		send(2'h0, 1'b0, 1'b0, 1'b1);
		send(2'h0, 1'b1, 1'b1, 1'b1);
		$display("test reload then store done");
		for (int k = 0; k < 6; k++) begin
			send(qwsc_pkg::qwsc_ch_t'($urandom), 1'($urandom), 1'($urandom), 1'b1);
		end
		$display("test random commands done");
		print_verdict();
	end
endmodule : quad_wiper_serial_control_tb

// *** verif/qwsc_props.sv ***
/*
 * Checker for the wiper link: edge discipline, driver enable, busy flag.
 * Assumes the host makes the link clock and srst resets both ends.
 */
`timescale 1ns/1ps
module qwsc_props (
	// clocks and reset
	input wire logic clk_sys,
	input wire logic srst,
	// link signals
	input wire logic link_clk,
	input wire logic chip_sel,
	input wire logic serial_in,
	input wire logic commit_request,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic store_done_flag
);
	// device link logic leaves reset a few link edges after srst
	logic [3:0] link_up;
	logic chk_off;
	always_ff @(posedge link_clk or posedge srst) begin
		if (srst) begin
			link_up <= 4'h0;
		end else begin
			link_up <= {link_up[2:0], 1'b1};
		end
	end
	assign chk_off = srst || !link_up[3];
	// link edge number in a frame, 1 at the start bit
	logic [3:0] cnt;
	// async clear: the link clock is still while srst is high
	always_ff @(posedge link_clk or posedge srst) begin
		if (srst) begin
			cnt <= 4'h0;
		end else if (!chip_sel) begin
			cnt <= 4'h0;
		end else if (cnt == 4'h0 || cnt == 4'hd) begin
			cnt <= {3'h0, serial_in & store_done_flag};
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	sequence frame_start;
		(cnt == 4'h0 || cnt == 4'hd) && chip_sel && serial_in && store_done_flag;
	endsequence
	sequence busy_run;
		!store_done_flag [*2];
	endsequence
	link_edge_a: assert property (@(posedge clk_sys) disable iff (chk_off)
		!$rose(link_clk) |-> $stable(serial_out) && $stable(serial_out_oe)
		&& $stable(store_done_flag)) else $error("link output moved off the rising edge");
	desel_oe_a: assert property (@(posedge link_clk) disable iff (chk_off)
		!chip_sel |=> !serial_out_oe) else $error("driver on while deselected");
	sel_oe_a: assert property (@(posedge link_clk) disable iff (chk_off)
		frame_start ##1 chip_sel [*8] |-> serial_out_oe) else $error("driver off in frame");
	busy_quiet_a: assert property (@(posedge link_clk) disable iff (chk_off)
		!store_done_flag && !$past(store_done_flag) |-> !serial_out_oe)
		else $error("driver on while busy");
	busy_cause_a: assert property (@(posedge link_clk) disable iff (chk_off)
		$fell(store_done_flag) |-> $past(commit_request) && cnt == 4'hc)
		else $error("busy without commit after last bit");
	no_commit_a: assert property (@(posedge link_clk) disable iff (chk_off)
		cnt == 4'hb && !commit_request |=> store_done_flag [*2])
		else $error("busy without commit");
	busy_hold_a: assert property (@(posedge link_clk) disable iff (chk_off)
		$fell(store_done_flag) |-> busy_run) else $error("busy too short");
	busy_end_a: assert property (@(posedge link_clk) disable iff (chk_off)
		$fell(store_done_flag) |-> ##[1:12] store_done_flag) else $error("busy never ends");
	commit_rise_a: assert property (@(posedge link_clk) disable iff (chk_off)
		$rose(commit_request) |-> cnt >= 4'h1 && cnt <= 4'ha) else $error("commit out of frame");
endmodule : qwsc_props
